// *** mrs_pkg.sv ***
// Purpose: Constants and types for the reset sequencer
// Assumes: One system clock, synchronous reset
// Notes: Register word offsets are byte addresses on the bus
package mrs_pkg;
  // Bus register map
  localparam logic [3:0] ADDR_FLAGS = 4'h0;
  localparam logic [3:0] ADDR_EVENTS = 4'h4;
  localparam logic [3:0] ADDR_MASK = 4'h8;
  localparam logic [3:0] ADDR_CTRL = 4'hc;
  // Event bit positions
  localparam int EV_DONE = 0;
  localparam int EV_PIN = 1;
  localparam int EV_WDT = 2;
  localparam int EV_WARM = 3;
  localparam int EV_WAKE = 4;
  localparam int EV_W = 5;
  localparam int CTRL_WDT_CLEAR = 0;
  localparam logic [EV_W-1:0] MASK_RESET = 5'h00;
  // Timing
  localparam int STARTUP_PULSES = 1024;
  localparam int STARTUP_CYCLES = STARTUP_PULSES * 1;
  localparam int OPTLOAD_CYCLES_DEF = 16;
  localparam int CNT_W = 11;
  // Register values loaded by a full reset
  localparam logic [10:0] PC_RESET = 11'h000;
  localparam logic [2:0] SP_RESET = 3'h0;
  localparam logic [7:0] INTERRUPT_CONTROL0_RESET = 8'h00;
  localparam logic [7:0] INTERRUPT_CONTROL1_RESET = 8'h00;
  localparam logic [7:0] TMRC_RESET = 8'h08;
  localparam logic [7:0] PORT_RESET = 8'hff;
  localparam logic [7:0] ADC_RESET = 8'h40;
  localparam logic [7:0] PPGC_RESET = 8'h00;
  localparam logic [7:0] MP_TOP = 8'h80;

  typedef enum logic [2:0] {
    ST_PIN_HELD, ST_STARTUP, ST_OPTLOAD, ST_RUN, ST_SLEEP
  } mrs_state_e;

  typedef struct packed {
    logic [10:0] program_counter;
    logic [2:0] stack_pointer;
    logic [7:0] interrupt_control0;
    logic [7:0] interrupt_control1;
    logic [7:0] timer0_control;
    logic [7:0] timer1_control;
    logic [7:0] port_a_data;
    logic [7:0] port_a_direction;
    logic [7:0] converter_control;
    logic [7:0] pulse_control;
  } mrs_init_s;

  typedef struct packed {
    logic pc_clear;
    logic sp_load;
    logic init_load;
    logic mp_top_set;
    logic timer_count_undef;
    logic warm_reset;
  } mrs_pulse_s;
endpackage

// *** mrs_reset_seq.sv ***
// Purpose: Reset sequencer with cause flags, start-up and option-load delays
// Assumes: Watchdog, wake and sleep-entry inputs are on clk_sys; pins are not
// Notes: Registers reached over classic Wishbone, one aligned word each
module mrs_reset_seq #(
  parameter int OPTLOAD_CYCLES = mrs_pkg::OPTLOAD_CYCLES_DEF
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic [3:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  output logic wb_ack_o,
  output logic irq,
  input wire logic reset_pin_n,
  input wire logic port_a_wake_pin,
  input wire logic watchdog_timeout,
  input wire logic sleep_enter,
  input wire logic interrupt_wake,
  output logic cpu_hold,
  output logic chip_reset,
  output logic watchdog_clear,
  output logic watchdog_timeout_flag,
  output logic powerdown_flag,
  output mrs_pkg::mrs_pulse_s pulses,
  output mrs_pkg::mrs_init_s init_values
);
  mrs_pkg::mrs_state_e state_reg;
  logic [mrs_pkg::CNT_W-1:0] cnt_reg;
  logic full_reg;
  logic pin_meta_reg, pin_sync_reg;
  logic pa_meta_reg, pa_sync_reg, pa_last_reg;
  logic [mrs_pkg::EV_W-1:0] events_reg, mask_reg, ev_set;
  logic wb_req, wb_wr;
  logic pin_low, pa_fall, wake_any;
  logic ev_pin, ev_wdt, ev_warm, ev_wake, ev_sleep, ev_full, ev_done;
  logic clr_wdt_cmd;
  logic cnt_last;

  // Pin synchronisers
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      pin_meta_reg <= 1'b1;
      pin_sync_reg <= 1'b1;
    end else begin
      pin_meta_reg <= reset_pin_n;
      pin_sync_reg <= pin_meta_reg;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      pa_meta_reg <= 1'b1;
      pa_sync_reg <= 1'b1;
      pa_last_reg <= 1'b1;
    end else begin
      pa_meta_reg <= port_a_wake_pin;
      pa_sync_reg <= pa_meta_reg;
      pa_last_reg <= pa_sync_reg;
    end
  end

  assign pin_low = ~pin_sync_reg;
  assign pa_fall = pa_last_reg & ~pa_sync_reg;
  assign wake_any = interrupt_wake | pa_fall;

  // Cause decode, pin reset has priority
  assign ev_pin = pin_low && state_reg != mrs_pkg::ST_PIN_HELD;
  assign ev_wdt = !pin_low && watchdog_timeout && state_reg == mrs_pkg::ST_RUN;
  assign ev_warm = !pin_low && watchdog_timeout && state_reg == mrs_pkg::ST_SLEEP;
  assign ev_wake = !pin_low && !watchdog_timeout && wake_any
    && state_reg == mrs_pkg::ST_SLEEP;
  assign ev_sleep = !pin_low && !watchdog_timeout && sleep_enter
    && state_reg == mrs_pkg::ST_RUN;
  assign ev_full = ev_pin | ev_wdt;
  assign ev_done = (state_reg == mrs_pkg::ST_STARTUP && cnt_last && !full_reg)
    || (state_reg == mrs_pkg::ST_OPTLOAD && cnt_last);

  always_comb begin
    cnt_last = 1'b0;
    unique case (state_reg)
      mrs_pkg::ST_STARTUP:
        cnt_last = cnt_reg == mrs_pkg::CNT_W'(mrs_pkg::STARTUP_CYCLES - 1);
      mrs_pkg::ST_OPTLOAD:
        cnt_last = cnt_reg == mrs_pkg::CNT_W'(OPTLOAD_CYCLES - 1);
      default: cnt_last = 1'b0;
    endcase
  end

  // Sequencer
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      state_reg <= mrs_pkg::ST_STARTUP;
      full_reg <= 1'b1;
      cnt_reg <= '0;
    end else if (ev_pin) begin
      state_reg <= mrs_pkg::ST_PIN_HELD;
      full_reg <= 1'b1;
      cnt_reg <= '0;
    end else begin
      unique case (state_reg)
        mrs_pkg::ST_PIN_HELD: begin
          cnt_reg <= '0;
          if (!pin_low) begin
            state_reg <= mrs_pkg::ST_STARTUP;
          end
        end
        mrs_pkg::ST_STARTUP: begin
          cnt_reg <= cnt_reg + 1'b1;
          if (cnt_last) begin
            cnt_reg <= '0;
            state_reg <= full_reg ? mrs_pkg::ST_OPTLOAD : mrs_pkg::ST_RUN;
          end
        end
        mrs_pkg::ST_OPTLOAD: begin
          cnt_reg <= cnt_reg + 1'b1;
          if (cnt_last) begin
            cnt_reg <= '0;
            state_reg <= mrs_pkg::ST_RUN;
            full_reg <= 1'b0;
          end
        end
        mrs_pkg::ST_RUN: begin
          cnt_reg <= '0;
          if (ev_wdt) begin
            state_reg <= mrs_pkg::ST_STARTUP;
            full_reg <= 1'b1;
          end else if (ev_sleep) begin
            state_reg <= mrs_pkg::ST_SLEEP;
          end
        end
        mrs_pkg::ST_SLEEP: begin
          cnt_reg <= '0;
          if (ev_warm || ev_wake) begin
            state_reg <= mrs_pkg::ST_STARTUP;
            full_reg <= 1'b0;
          end
        end
        default: begin
          state_reg <= mrs_pkg::ST_STARTUP;
          full_reg <= 1'b1;
          cnt_reg <= '0;
        end
      endcase
    end
  end

  // Timeout cause flag
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      watchdog_timeout_flag <= 1'b0;
    end else if (ev_pin) begin
      if (state_reg == mrs_pkg::ST_SLEEP) begin
        watchdog_timeout_flag <= 1'b0;
      end
    end else if (ev_wdt || ev_warm) begin
      watchdog_timeout_flag <= 1'b1;
    end else if (ev_sleep) begin
      watchdog_timeout_flag <= 1'b0;
    end
  end

  // Power-down cause flag, a cause wins over a same-cycle clear
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      powerdown_flag <= 1'b0;
    end else if (ev_pin) begin
      if (state_reg == mrs_pkg::ST_SLEEP) begin
        powerdown_flag <= 1'b1;
      end
    end else if (ev_warm) begin
      powerdown_flag <= 1'b1;
    end else if (ev_sleep) begin
      powerdown_flag <= 1'b1;
    end else if (!ev_wdt && clr_wdt_cmd) begin
      powerdown_flag <= 1'b0;
    end
  end

  // Reset side effects as one-cycle pulses
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      pulses <= '0;
      pulses.pc_clear <= 1'b1;
      pulses.sp_load <= 1'b1;
      pulses.init_load <= 1'b1;
    end else begin
      pulses.pc_clear <= ev_full | ev_warm;
      pulses.sp_load <= ev_full | ev_warm;
      pulses.init_load <= ev_full;
      pulses.mp_top_set <= ev_full;
      pulses.timer_count_undef <= ev_wdt;
      pulses.warm_reset <= ev_warm;
    end
  end

  // Values carried with the load pulses
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      init_values.program_counter <= mrs_pkg::PC_RESET;
      init_values.stack_pointer <= mrs_pkg::SP_RESET;
      init_values.interrupt_control0 <= mrs_pkg::INTERRUPT_CONTROL0_RESET;
      init_values.interrupt_control1 <= mrs_pkg::INTERRUPT_CONTROL1_RESET;
      init_values.timer0_control <= mrs_pkg::TMRC_RESET;
      init_values.timer1_control <= mrs_pkg::TMRC_RESET;
      init_values.port_a_data <= mrs_pkg::PORT_RESET;
      init_values.port_a_direction <= mrs_pkg::PORT_RESET;
      init_values.converter_control <= mrs_pkg::ADC_RESET;
      init_values.pulse_control <= mrs_pkg::PPGC_RESET;
    end
  end

  // Status outputs
  always_comb begin
    cpu_hold = state_reg != mrs_pkg::ST_RUN;
    chip_reset = full_reg && state_reg != mrs_pkg::ST_RUN;
    watchdog_clear = chip_reset | ev_sleep;
  end

  // Wishbone slave
  assign wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign wb_wr = wb_req & wb_we_i & wb_sel_i[0];
  assign clr_wdt_cmd = wb_wr && wb_adr_i == mrs_pkg::ADDR_CTRL
    && wb_dat_i[mrs_pkg::CTRL_WDT_CLEAR];

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= '0;
    end else begin
      wb_ack_o <= wb_req;
      wb_dat_o <= '0;
      if (wb_req && !wb_we_i) begin
        unique case (wb_adr_i)
          mrs_pkg::ADDR_FLAGS:
            wb_dat_o <= {24'h000000, 1'b0, state_reg, full_reg, cpu_hold,
              powerdown_flag, watchdog_timeout_flag};
          mrs_pkg::ADDR_EVENTS: wb_dat_o <= {27'h0000000, events_reg};
          mrs_pkg::ADDR_MASK: wb_dat_o <= {27'h0000000, mask_reg};
          default: wb_dat_o <= '0;
        endcase
      end
    end
  end

  // Interrupt events, set wins over clear
  always_comb begin
    ev_set = '0;
    ev_set[mrs_pkg::EV_DONE] = ev_done;
    ev_set[mrs_pkg::EV_PIN] = ev_pin;
    ev_set[mrs_pkg::EV_WDT] = ev_wdt;
    ev_set[mrs_pkg::EV_WARM] = ev_warm;
    ev_set[mrs_pkg::EV_WAKE] = ev_wake;
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      events_reg <= '0;
    end else if (wb_wr && wb_adr_i == mrs_pkg::ADDR_EVENTS) begin
      events_reg <= (events_reg & ~wb_dat_i[mrs_pkg::EV_W-1:0]) | ev_set;
    end else begin
      events_reg <= events_reg | ev_set;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      mask_reg <= mrs_pkg::MASK_RESET;
    end else if (wb_wr && wb_adr_i == mrs_pkg::ADDR_MASK) begin
      mask_reg <= wb_dat_i[mrs_pkg::EV_W-1:0];
    end
  end

  assign irq = |(events_reg & mask_reg);
endmodule // mrs_reset_seq

// *** mrs_checker.sv ***
// Purpose: Port assertions for the reset sequencer
// Assumes: One clock, synchronous reset
// Notes: Bound to every sequencer instance
module mrs_checker #(
  parameter int OPTLOAD_CYCLES = 16
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  input wire logic cpu_hold,
  input wire logic chip_reset,
  input wire logic watchdog_clear,
  input wire logic watchdog_timeout_flag,
  input wire logic powerdown_flag,
  input wire mrs_pkg::mrs_pulse_s pulses,
  input wire mrs_pkg::mrs_init_s init_values
);
  logic [15:0] hold_reg;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  // Cycles spent with execution held
  always_ff @(posedge clk_sys) begin
    if (rst || !cpu_hold) begin
      hold_reg <= 16'h0000;
    end else if (hold_reg != 16'hffff) begin
      hold_reg <= hold_reg + 16'h0001;
    end
  end
  a_ack_follows: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("ack missing");
  a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack too long");
  a_startup_hold: assert property (!cpu_hold && hold_reg != 0 |-> hold_reg >= 1024)
    else $error("hold too short");
  a_optload_full: assert property ($fell(chip_reset) |-> hold_reg >= 1024 + OPTLOAD_CYCLES)
    else $error("option load too short");
  a_warm_only: assert property (pulses.warm_reset |-> !chip_reset && !pulses.init_load
    && pulses.pc_clear && pulses.sp_load) else $error("warm reset wrong");
  a_warm_flags: assert property (pulses.warm_reset |-> watchdog_timeout_flag && powerdown_flag)
    else $error("warm flags wrong");
  a_clear_reset: assert property (chip_reset |-> watchdog_clear)
    else $error("watchdog not cleared");
  a_init_vals: assert property (pulses.init_load |-> init_values.port_a_data == 8'hff
    && init_values.converter_control == 8'h40 && init_values.timer0_control == 8'h08)
    else $error("init values wrong");
  a_pc_zero: assert property (pulses.pc_clear |-> init_values.program_counter == 11'h000)
    else $error("pc not zero");
  a_mp_full: assert property (pulses.mp_top_set |-> pulses.init_load)
    else $error("pointer set off full reset");
  a_undef_wdt: assert property (pulses.timer_count_undef |-> watchdog_timeout_flag && chip_reset)
    else $error("undef pulse wrong");
  c_warm: cover property (pulses.warm_reset);
  c_wdt_run: cover property (pulses.timer_count_undef);
  c_full_end: cover property ($fell(chip_reset));
endmodule // mrs_checker

bind mrs_reset_seq mrs_checker #(.OPTLOAD_CYCLES(OPTLOAD_CYCLES)) chk (
  .clk_sys(clk_sys), .rst(rst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_ack_o(wb_ack_o), .cpu_hold(cpu_hold), .chip_reset(chip_reset),
  .watchdog_clear(watchdog_clear), .watchdog_timeout_flag(watchdog_timeout_flag),
  .powerdown_flag(powerdown_flag), .pulses(pulses), .init_values(init_values)
);

// *** mrs_partner.sv ***
// Purpose: Reset pin driver and watchdog overflow source
// Assumes: Pin has a pull-up, so released reads high
// Notes: Tasks are called by the bench
module mrs_partner (
  input wire logic clk_sys,
  output logic reset_pin_n,
  output logic watchdog_timeout
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    reset_pin_n = 1'b1;
    watchdog_timeout = 1'b0;
  end
  // Pin held low for n clocks
  task automatic press(input int n);
    @(posedge clk_sys);
    reset_pin_n <= 1'b0;
    repeat (n) @(posedge clk_sys);
    reset_pin_n <= 1'b1;
  endtask
  // One overflow pulse
  task automatic overflow();
    @(posedge clk_sys);
    watchdog_timeout <= 1'b1;
    @(posedge clk_sys);
    watchdog_timeout <= 1'b0;
  endtask
endmodule // mrs_partner

// *** mrs_reset_seq_tb.sv ***
// Purpose: Self-checking bench for the reset sequencer
// Assumes: Option load set to 16 clocks, the package default
// Notes: Flags read at ports and over the bus
module mrs_reset_seq_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int OPT = 16;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic [3:0] wb_adr_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h0;
  logic wb_we_i = 1'b0;
  logic wb_cyc_i = 1'b0;
  logic wb_stb_i = 1'b0;
  logic port_a_wake_pin = 1'b1;
  logic sleep_enter = 1'b0;
  logic interrupt_wake = 1'b0;
  logic [31:0] wb_dat_o, rd;
  logic wb_ack_o, irq, reset_pin_n, watchdog_timeout, cpu_hold, to_f, pd_f;
  mrs_pkg::mrs_init_s iv;
  int n_mismatch = 0;
  int tests_run = 0;
  int cycles = 0;
  int n;
  always #4 clk_sys = ~clk_sys;
  mrs_partner partner (.clk_sys(clk_sys), .reset_pin_n(reset_pin_n),
    .watchdog_timeout(watchdog_timeout));
  mrs_reset_seq #(.OPTLOAD_CYCLES(OPT)) dut (.clk_sys(clk_sys), .rst(rst),
    .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_we_i(wb_we_i),
    .wb_sel_i(4'hf), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o),
    .irq(irq), .reset_pin_n(reset_pin_n), .port_a_wake_pin(port_a_wake_pin),
    .watchdog_timeout(watchdog_timeout), .sleep_enter(sleep_enter),
    .interrupt_wake(interrupt_wake), .cpu_hold(cpu_hold), .chip_reset(),
    .watchdog_clear(), .watchdog_timeout_flag(to_f), .powerdown_flag(pd_f),
    .pulses(), .init_values(iv));
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic close_out();
    $display("Checks %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 20000) begin
      n_mismatch++;
      close_out();
    end
  end
  task automatic bus(input logic we, input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    repeat (50) begin
      @(posedge clk_sys);
      if (wb_ack_o === 1'b1) break;
    end
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask
  // The first edge lets a cause launched on the calling edge raise cpu_hold
  task automatic wait_run();
    n = 0;
    @(posedge clk_sys);
    while (cpu_hold !== 1'b0 && n < 3000) begin
      @(posedge clk_sys);
      n++;
    end
  endtask
  task automatic t_power();
    wait_run();
    check("hold", n >= 1024 + OPT, 1);
    check("flags", {to_f, pd_f}, 2'b00);
    bus(1'b0, mrs_pkg::ADDR_FLAGS, 0);
    check("flag reg", rd, 32'h30);
    check("ports", {iv.port_a_data, iv.port_a_direction}, 16'hffff);
    check("ctl", {iv.converter_control, iv.pulse_control, iv.interrupt_control0}, 24'h400000);
    $display("t_power done");
  endtask
  // Sleep, then wake by interrupt, port A, watchdog or pin
  task automatic t_sleep(input int m);
    logic [1:0] fl [4] = '{2'b01, 2'b01, 2'b11, 2'b01};
    @(posedge clk_sys);
    sleep_enter <= 1'b1;
    @(posedge clk_sys);
    sleep_enter <= 1'b0;
    repeat (3) @(posedge clk_sys);
    check("sleep flags", {to_f, pd_f}, 2'b01);
    if (m == 0) begin
      interrupt_wake <= 1'b1;
      @(posedge clk_sys);
      interrupt_wake <= 1'b0;
    end else if (m == 1) begin
      port_a_wake_pin <= 1'b0;
    end else if (m == 2) begin
      partner.overflow();
    end else begin
      partner.press(4);
    end
    wait_run();
    port_a_wake_pin <= 1'b1;
    check("wake flags", {to_f, pd_f}, fl[m]);
    check("wake hold", (m == 3) ? n >= 1024 + OPT : n >= 1024 && n < 1024 + OPT, 1);
    $display("t_sleep %0d done", m);
  endtask
  task automatic t_run();
    partner.press(4);
    wait_run();
    check("pin run", {to_f, pd_f, n >= 1024 + OPT}, 3'b011);
    bus(1'b1, mrs_pkg::ADDR_CTRL, 1);
    check("clear pd", {to_f, pd_f}, 2'b00);
    partner.overflow();
    wait_run();
    check("wdt run", {to_f, pd_f, n >= 1024 + OPT}, 3'b101);
    $display("t_run done");
  endtask
  task automatic t_irq();
    bus(1'b1, mrs_pkg::ADDR_EVENTS, 32'h1f);
    bus(1'b1, mrs_pkg::ADDR_MASK, 32'h04);
    check("irq idle", irq, 0);
    partner.overflow();
    wait_run();
    check("irq set", irq, 1);
    bus(1'b0, mrs_pkg::ADDR_EVENTS, 0);
    check("events", rd, 32'h05);
    bus(1'b1, mrs_pkg::ADDR_EVENTS, 32'h04);
    check("irq clr", irq, 0);
    bus(1'b0, 4'h1, 0);
    check("unmapped", rd, 0);
    $display("t_irq done");
  endtask
  initial begin
    repeat (8) @(posedge clk_sys);
    rst <= 1'b0;
    t_power();
    for (int m = 0; m < 4; m++) begin
      t_sleep(m);
    end
    t_run();
    t_irq();
    close_out();
  end
endmodule // mrs_reset_seq_tb
